// File: rtl/lsor_ctrl.sv
// Purpose: Master/slave outlet controller driven by a metering pulse train
// Assumes: Pulse input synchronous to i_clk
// Notes: Power compared in the interval domain
// Operation
// - Filtered load power is compared with a fixed 30 W threshold.
// - Power above threshold switches the slave relay drive on.
// - Power below threshold switches the slave relay drive off.
// - The slave relay drive changes only after the load decision held 100 ms.
// - Intervals between metering pulse rising edges are measured.
// - A periodic tick is produced every 20 ms.
// - 200 ms of ticks with no pulse sets the no-load timeout.
// - No load, load off or load under 30 W keeps the slave relay drive off.
// - The master relay drive turns on once initialisation ends.
// - The power estimate is a trimmed mean of several intervals.
// - Two independent relay drive outputs exist.
`include "lsor_consts.svh"
module lsor_ctrl
    import lsor_pkg::*;
#(
    parameter int DELAY_CYC = `LSOR_DELAY_CYC,
    parameter int TICK_CYC = `LSOR_TICK_CYC,
    parameter int THRESH_CYC = `LSOR_THRESH_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Metering pulse
    input wire logic i_metering_pulse_input,
    // Relay drives and no-load flag
    output logic o_master_relay_drive,
    output logic o_slave_relay_drive,
    output logic o_no_load
);
    import lsor_pkg::*;

    // Delay and tick of one cycle would leave no room for the hold and spacing checks
    if (DELAY_CYC < 2 || TICK_CYC < 2 || THRESH_CYC < 1 || THRESH_CYC >= (1 << 24)) begin : g_bad_param
        $error("lsor_ctrl: bad parameter");
    end

    function automatic logic lsor_is_run(input lsor_state_e s);
        return s == LSOR_RUN;
    endfunction : lsor_is_run

    // =========================================
    // State and timers
    lsor_state_e st_r, st_nxt;
    logic [4:0] init_r, init_nxt;
    logic pin_r, pin_nxt;
    lsor_ivl_t ivl_r, ivl_nxt;
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic [3:0] ticks_r, ticks_nxt;
    logic nold_r, nold_nxt;
    logic load_r, load_nxt;
    logic [31:0] dly_r, dly_nxt;
    logic mst_r, mst_nxt;
    logic slv_r, slv_nxt;
    logic edge_p, tick_p, want, f_vld;
    lsor_ivl_t f_mean;

    assign edge_p = i_metering_pulse_input && !pin_r && lsor_is_run(st_r);
    assign tick_p = lsor_is_run(st_r) && (tick_cnt_r == 32'(TICK_CYC - 1));
    // Slave wanted only with pulses present and power over threshold
    assign want = load_r && !nold_r;

    lsor_trim_mean #(.W(24)) u_filt (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_clr(st_r == LSOR_INIT),
        .i_vld(edge_p),
        .i_smp(ivl_r),
        .o_vld(f_vld),
        .o_mean(f_mean)
    );

    always_comb begin
        st_nxt = st_r;
        init_nxt = init_r;
        pin_nxt = i_metering_pulse_input;
        ivl_nxt = ivl_r;
        tick_cnt_nxt = tick_cnt_r;
        ticks_nxt = ticks_r;
        nold_nxt = nold_r;
        load_nxt = load_r;
        dly_nxt = dly_r;
        mst_nxt = mst_r;
        slv_nxt = slv_r;
        unique case (st_r)
            LSOR_INIT: begin
                if (init_r == 5'(`LSOR_INIT_CYC - 1)) begin
                    st_nxt = LSOR_RUN;
                    mst_nxt = 1'b1;
                end else begin
                    init_nxt = init_r + 5'h1;
                end
            end
            LSOR_RUN: begin
                // Interval counter saturates
                if (edge_p) begin
                    ivl_nxt = 24'h000001;
                end else if (ivl_r != 24'hFFFFFF) begin
                    ivl_nxt = ivl_r + 24'h000001;
                end
                tick_cnt_nxt = tick_p ? 32'h0 : tick_cnt_r + 32'h1;
                if (edge_p) begin
                    ticks_nxt = 4'h0;
                    nold_nxt = 1'b0;
                end else if (tick_p) begin
                    if (ticks_r == 4'(`LSOR_TIMEOUT_TICKS - 1)) begin
                        nold_nxt = 1'b1;
                    end else begin
                        ticks_nxt = ticks_r + 4'h1;
                    end
                end
                if (f_vld) begin
                    load_nxt = (f_mean < 24'(THRESH_CYC));
                end
                if (nold_r) begin
                    load_nxt = 1'b0;
                end
                // Decision must hold for the full delay before the drive moves
                if (want == slv_r) begin
                    dly_nxt = 32'h0;
                end else if (dly_r == 32'(DELAY_CYC - 1)) begin
                    dly_nxt = 32'h0;
                    slv_nxt = want;
                end else begin
                    dly_nxt = dly_r + 32'h1;
                end
            end
            default: begin
                st_nxt = LSOR_INIT;
                init_nxt = 5'h0;
                mst_nxt = 1'b0;
                slv_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= LSOR_INIT;
            init_r <= 5'h0;
            pin_r <= 1'b0;
            ivl_r <= 24'h000000;
            tick_cnt_r <= 32'h0;
            ticks_r <= 4'h0;
            nold_r <= 1'b0;
            load_r <= 1'b0;
            dly_r <= 32'h0;
            mst_r <= 1'b0;
            slv_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            init_r <= init_nxt;
            pin_r <= pin_nxt;
            ivl_r <= ivl_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            ticks_r <= ticks_nxt;
            nold_r <= nold_nxt;
            load_r <= load_nxt;
            dly_r <= dly_nxt;
            mst_r <= mst_nxt;
            slv_r <= slv_nxt;
        end
    end

    // Two separate relay drives
    assign o_master_relay_drive = mst_r;
    assign o_slave_relay_drive = slv_r;
    assign o_no_load = nold_r;

    // =========================================
    // Assertions
    property p_slv_hold;
        @(posedge i_clk) disable iff (!i_rst_b)
        (slv_r != want) && (dly_r == 32'h0) |=> (slv_r == $past(slv_r));
    endproperty
    a_slv_hold: assert property (p_slv_hold) else $error("slave drive moved early");

    property p_slv_on;
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(slv_r) |-> $past(want) && $past(dly_r) == 32'(DELAY_CYC - 1);
    endproperty
    a_slv_on: assert property (p_slv_on) else $error("slave on without delay");

    property p_slv_off;
        @(posedge i_clk) disable iff (!i_rst_b)
        $fell(slv_r) |-> !$past(want);
    endproperty
    a_slv_off: assert property (p_slv_off) else $error("slave off without cause");

    property p_noload;
        @(posedge i_clk) disable iff (!i_rst_b)
        nold_r |-> !load_r || $past(!nold_r);
    endproperty
    a_noload: assert property (p_noload) else $error("load kept under timeout");

    property p_thresh;
        @(posedge i_clk) disable iff (!i_rst_b)
        f_vld && !nold_r |=> (load_r == ($past(f_mean) < 24'(THRESH_CYC)));
    endproperty
    a_thresh: assert property (p_thresh) else $error("threshold compare wrong");

    property p_tick;
        @(posedge i_clk) disable iff (!i_rst_b)
        tick_p |=> !tick_p;
    endproperty
    a_tick: assert property (p_tick) else $error("tick too close");

    property p_timeout;
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(nold_r) |-> $past(tick_p) && $past(ticks_r) == 4'(`LSOR_TIMEOUT_TICKS - 1);
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout at wrong time");

    property p_master;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st_r == LSOR_RUN) |-> mst_r;
    endproperty
    a_master: assert property (p_master) else $error("master off while running");

    property p_init;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st_r == LSOR_INIT) |-> !mst_r && !slv_r && !nold_r;
    endproperty
    a_init: assert property (p_init) else $error("relay on during init");

    c_slv_on: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(slv_r));
    c_slv_off: cover property (@(posedge i_clk) disable iff (!i_rst_b) $fell(slv_r));
    c_noload: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(nold_r));
endmodule : lsor_ctrl

// File: rtl/lsor_consts.svh
// Purpose: Constants of the load sense outlet relay controller
// Assumes: 50 MHz system clock
// Notes: Times in their own unit, tick and delay cycle counts derived, threshold and init counts given directly
`ifndef LSOR_CONSTS_SVH
`define LSOR_CONSTS_SVH
`define LSOR_CLK_HZ 50000000
`define LSOR_TICK_MS 20
`define LSOR_TICK_CYC ((`LSOR_CLK_HZ / 1000) * `LSOR_TICK_MS)
`define LSOR_TIMEOUT_MS 200
`define LSOR_TIMEOUT_TICKS (`LSOR_TIMEOUT_MS / `LSOR_TICK_MS)
`define LSOR_DELAY_MS 100
`define LSOR_DELAY_CYC ((`LSOR_CLK_HZ / 1000) * `LSOR_DELAY_MS)
`define LSOR_THRESH_W 30
// Interval of the metering pulse at the threshold power, in cycles
`define LSOR_THRESH_CYC 500000
`define LSOR_INIT_CYC 16
`endif

// File: rtl/lsor_pkg.sv
// Purpose: Types of the load sense outlet relay controller
// Assumes: Nothing
// Notes: Constants live in lsor_consts.svh
package lsor_pkg;
    typedef enum logic [1:0] {
        LSOR_INIT = 2'b00,
        LSOR_RUN = 2'b01
    } lsor_state_e;
    typedef logic [23:0] lsor_ivl_t;
endpackage : lsor_pkg

// File: rtl/lsor_trim_mean.sv
// Purpose: Trimmed mean of four interval samples
// Assumes: One sample per i_vld pulse
// Notes: Drops largest and smallest, averages the middle two
module lsor_trim_mean
    import lsor_pkg::*;
#(
    parameter int W = 24
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Samples
    input wire logic i_clr,
    input wire logic i_vld,
    input wire logic [W-1:0] i_smp,
    // Result
    output logic o_vld,
    output logic [W-1:0] o_mean
);
    if (W < 2) begin : g_bad_width
        $error("lsor_trim_mean: bad width");
    end

    // =========================================
    // Sample window
    logic [W-1:0] win_r [4];
    logic [W-1:0] win_nxt [4];
    logic [2:0] cnt_r, cnt_nxt;
    logic vld_r, vld_nxt;
    logic [W-1:0] mean_r, mean_nxt;
    logic [W+1:0] sum;
    logic [W-1:0] mx, mn;

    always_comb begin
        sum = '0;
        mx = win_r[0];
        mn = win_r[0];
        for (int k = 0; k < 4; k++) begin
            sum = sum + (W+2)'(win_r[k]);
            if (win_r[k] > mx) begin
                mx = win_r[k];
            end
            if (win_r[k] < mn) begin
                mn = win_r[k];
            end
        end
        sum = sum - (W+2)'(mx) - (W+2)'(mn);
        win_nxt = win_r;
        cnt_nxt = cnt_r;
        vld_nxt = 1'b0;
        mean_nxt = mean_r;
        if (i_clr) begin
            cnt_nxt = '0;
        end else if (i_vld) begin
            win_nxt[0] = i_smp;
            for (int k = 1; k < 4; k++) begin
                win_nxt[k] = win_r[k-1];
            end
            if (cnt_r < 3'h4) begin
                cnt_nxt = cnt_r + 3'h1;
            end
        end else if (cnt_r == 3'h4) begin
            vld_nxt = 1'b1;
            mean_nxt = sum[W:1];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int k = 0; k < 4; k++) begin
                win_r[k] <= '0;
            end
            cnt_r <= '0;
            vld_r <= 1'b0;
            mean_r <= '0;
        end else begin
            win_r <= win_nxt;
            cnt_r <= cnt_nxt;
            vld_r <= vld_nxt;
            mean_r <= mean_nxt;
        end
    end

    assign o_vld = vld_r;
    assign o_mean = mean_r;
endmodule : lsor_trim_mean

// File: sim/lsor_meter_model.sv
// Purpose: Behavioural metering chip giving a square wave pulse train
// Assumes: Period in i_clk cycles, zero stops the wave
// Notes: A shorter period stands for a higher load power
// ============================================================
// Meter model
module lsor_meter_model (
    // Clock
    input wire logic i_clk,
    // Control from the bench
    input wire logic [15:0] i_period,
    // Pulse to the controller
    output logic o_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] cnt_r = 16'h0000;
    initial o_pulse = 1'b0;
    always @(posedge i_clk) begin
        if (i_period == 16'h0000) begin
            // A stopped meter holds its output low
            cnt_r <= 16'h0000;
            o_pulse <= 1'b0;
        end else begin
            cnt_r <= (cnt_r + 16'h0001 >= i_period) ? 16'h0000 : cnt_r + 16'h0001;
            o_pulse <= (cnt_r < (i_period >> 1));
        end
    end
endmodule : lsor_meter_model

// File: sim/tb_top.sv
// Purpose: Self-checking bench of the outlet relay controller
// Assumes: Shortened delay, tick and threshold counts
// Notes: Period above 100 cycles means load below threshold
// ============================================================
// Bench top
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DLY = 50;
    localparam int LIMIT = 20000;
    typedef struct {
        logic [15:0] period;
        logic slave;
        logic no_load;
    } lsor_row_s;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [15:0] period = 16'h0000;
    logic pulse;
    logic master;
    logic slave;
    logic no_load;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;
    lsor_row_s rows [7] = '{
        '{16'h0028, 1'b1, 1'b0}, '{16'h005F, 1'b1, 1'b0}, '{16'h0064, 1'b0, 1'b0},
        '{16'h0069, 1'b0, 1'b0}, '{16'h0096, 1'b0, 1'b0}, '{16'h003C, 1'b1, 1'b0},
        '{16'h0000, 1'b0, 1'b1}};

    always #10 i_clk = ~i_clk;

    lsor_meter_model meter (.i_clk(i_clk), .i_period(period), .o_pulse(pulse));

    lsor_ctrl #(.DELAY_CYC(DLY), .TICK_CYC(20), .THRESH_CYC(100)) dut (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_metering_pulse_input(pulse),
        .o_master_relay_drive(master),
        .o_slave_relay_drive(slave),
        .o_no_load(no_load)
    );

    // ============================================================
    // Helpers
    task automatic check(input string name, input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %b seen %b", name, exp, seen);
        end
    endtask : check

    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask : cyc

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ============================================================
    // Sequence
    initial begin
        cyc(4);
        check("master_in_reset", master, 1'b0);
        check("slave_in_reset", slave, 1'b0);
        check("noload_in_reset", no_load, 1'b0);
        cyc(1);
        i_rst_b = 1'b1;
        cyc(10);
        check("master_during_init", master, 1'b0);
        cyc(10);
        check("master_after_init", master, 1'b1);
        $display("test reset done");
        foreach (rows[i]) begin
            period = rows[i].period;
            cyc(rows[i].period == 16'h0000 ? 400 : 6 * int'(rows[i].period) + 100);
            check("row_slave", slave, rows[i].slave);
            check("row_noload", no_load, rows[i].no_load);
            check("row_master", master, 1'b1);
            $display("test row %0d done", i);
        end
        // Stop the meter right after a pulse and time the timeout
        period = 16'h0028;
        cyc(400);
        check("slave_before_stop", slave, 1'b1);
        @(posedge pulse);
        #1;
        period = 16'h0000;
        n = 0;
        while (no_load !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        check("timeout_window", (n >= 179 && n <= 221), 1'b1);
        cyc(DLY - 5);
        check("slave_held_in_delay", slave, 1'b1);
        cyc(15);
        check("slave_off_after_delay", slave, 1'b0);
        period = 16'h0028;
        cyc(100);
        check("noload_cleared", no_load, 1'b0);
        cyc(300);
        check("slave_back_on", slave, 1'b1);
        $display("test timeout and delay done");
        // One long interval among short ones must be trimmed away
        period = 16'h0050;
        cyc(500);
        check("slave_before_outlier", slave, 1'b1);
        @(posedge pulse);
        #1;
        period = 16'h00A0;
        @(posedge pulse);
        #1;
        period = 16'h0050;
        cyc(120);
        check("slave_outlier_early", slave, 1'b1);
        cyc(120);
        check("slave_outlier_late", slave, 1'b1);
        $display("test outlier done");
        // Reset in mid-run with the slave relay on
        i_rst_b = 1'b0;
        #1;
        check("master_mid_reset", master, 1'b0);
        check("slave_mid_reset", slave, 1'b0);
        cyc(3);
        i_rst_b = 1'b1;
        cyc(10);
        check("master_reinit", master, 1'b0);
        cyc(10);
        check("master_rerun", master, 1'b1);
        check("slave_rerun", slave, 1'b0);
        $display("test mid reset done");
        report_and_stop();
    end
endmodule : tb_top
